// [schp_card_model.sv]
`timescale 1ns/1ps
// Connector with detect switch
module schp_card_model (
	input  wire logic i_inserted,
	input  wire logic i_glitch,
	output logic      o_detect
);
	// switch fitted
	// Closed switch drives high; glitch mimics contact bounce
	assign o_detect = i_inserted ^ i_glitch;
endmodule : schp_card_model

// [schp_filter.sv]
`timescale 1ns/1ps
// Two-flop synchroniser plus stable-count filter
module schp_filter
	import schp_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_reset,
	input  wire logic i_raw,
	output logic      o_level
);

	typedef struct packed {
		logic             s1;
		logic             s2;
		logic             lvl;
		logic [DEB_W-1:0] cnt;
	} schp_flt_t;

	schp_flt_t st_q;
	schp_flt_t st_d;

	// ****************************************
	// Filter next state
	// ****************************************
	always_comb begin
		st_d    = st_q;
		st_d.s1 = i_raw;
		st_d.s2 = st_q.s1; // Only s2 reads s1
		if (st_q.s2 == st_q.lvl) begin
			st_d.cnt = '0;
		end else if (st_q.cnt == DEB_W'(DEBOUNCE_CYCLES - 1)) begin
			st_d.lvl = st_q.s2; // Stable long enough
			st_d.cnt = '0;
		end else begin
			st_d.cnt = st_q.cnt + DEB_W'(1);
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_level = st_q.lvl;

endmodule : schp_filter

// [schp_pkg.sv]
package schp_pkg;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_DETECT_ENABLE = 1'h1;
	localparam logic RST_POLARITY      = 1'h1;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLOCK_MHZ       = 200;
	localparam int DEBOUNCE_US     = 10;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLOCK_MHZ;
	localparam int DEB_W           = $clog2(DEBOUNCE_CYCLES + 1);

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_NO_CARD   = 3'h0,
		ST_CARD_INIT = 3'h1,
		ST_REGISTER  = 3'h2,
		ST_READY     = 3'h3,
		ST_LOCKED    = 3'h4
	} schp_state_t;

	// Configuration carried as one group
	typedef struct packed {
		logic hot_plug_detect_enable_cmd;
		logic detect_polarity_select;
	} schp_cfg_t;

	// Events and status toward the card stack
	typedef struct packed {
		logic card_present;
		logic card_access_en;
		logic init_start;
		logic reg_start;
		logic insert_evt;
		logic remove_evt;
	} schp_stat_t;

endpackage : schp_pkg

// [schp_top.sv]
`timescale 1ns/1ps
// Card presence detection and card bring-up sequencing
module schp_top
	import schp_pkg::*;
(
	input  wire logic         i_clock,
	input  wire logic         i_reset,
	input  wire logic         i_card_detect_in,
	input  schp_pkg::schp_cfg_t i_cfg,
	input  wire logic         i_cfg_write,
	input  wire logic         i_init_done,
	output schp_pkg::schp_cfg_t o_cfg,
	output schp_pkg::schp_stat_t o_stat
);
	import schp_pkg::*;

	typedef struct packed {
		schp_state_t fsm;
		schp_cfg_t   cfg;
		logic        boot_read; // Power-up read already issued
		schp_stat_t  stat;
	} schp_top_st_t;

	schp_top_st_t st_q;
	schp_top_st_t st_d;
	logic         raw_level;
	logic         active;

	schp_filter u_filter (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_raw   (i_card_detect_in),
		.o_level (raw_level)
	);

	assign active = st_q.cfg.detect_polarity_select ? raw_level : ~raw_level;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		st_d                 = st_q;
		st_d.stat.init_start = 1'h0;
		st_d.stat.reg_start  = 1'h0;
		st_d.stat.insert_evt = 1'h0;
		st_d.stat.remove_evt = 1'h0;
		if (i_cfg_write) begin
			st_d.cfg = i_cfg;
		end
		unique case (st_q.fsm)
			ST_NO_CARD: begin
				if (st_q.cfg.hot_plug_detect_enable_cmd && active) begin
					st_d.fsm             = ST_CARD_INIT;
					st_d.stat.init_start = 1'h1;
					st_d.stat.insert_evt = 1'h1;
				end else if (!st_q.cfg.hot_plug_detect_enable_cmd && !st_q.boot_read) begin
					st_d.fsm             = ST_CARD_INIT;
					st_d.boot_read       = 1'h1;
					st_d.stat.init_start = 1'h1;
				end
			end
			ST_CARD_INIT: begin
				if (i_init_done) begin
					st_d.fsm            = ST_REGISTER;
					st_d.stat.reg_start = 1'h1;
				end
			end
			ST_REGISTER: begin
				st_d.fsm = ST_READY;
			end
			ST_READY, ST_LOCKED: begin
			end
			default: begin
				st_d.fsm = ST_NO_CARD;
			end
		endcase
		// Removal overrides any sequence step
		if (st_q.fsm != ST_NO_CARD && st_q.cfg.hot_plug_detect_enable_cmd && !active) begin
			st_d.fsm             = ST_NO_CARD;
			st_d.stat.init_start = 1'h0;
			st_d.stat.reg_start  = 1'h0;
			st_d.stat.remove_evt = 1'h1;
		end
		// Any card seen at all counts as the power-up read
		if (st_d.fsm != ST_NO_CARD) begin
			st_d.boot_read = 1'h1;
		end
		st_d.stat.card_present   = (st_d.fsm != ST_NO_CARD);
		st_d.stat.card_access_en = (st_d.fsm != ST_NO_CARD);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			st_q.fsm       <= ST_NO_CARD;
			st_q.cfg       <= '{RST_DETECT_ENABLE, RST_POLARITY};
			st_q.boot_read <= 1'h0;
			st_q.stat      <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_cfg  = st_q.cfg;
	assign o_stat = st_q.stat;

endmodule : schp_top

// [schp_top_asserts.sv]
`timescale 1ns/1ps
// Port-level checks on the detect block
module schp_top_chk
	import schp_pkg::*;
(
	input wire logic            i_clock,
	input wire logic            i_reset,
	input wire logic            i_card_detect_in,
	input schp_pkg::schp_cfg_t  i_cfg,
	input wire logic            i_cfg_write,
	input wire logic            i_init_done,
	input schp_pkg::schp_cfg_t  o_cfg,
	input schp_pkg::schp_stat_t o_stat
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	// Each event is tied to its cause
	a_insert_init: assert property (o_stat.insert_evt |-> o_stat.init_start && o_stat.card_access_en)
		else $error("insert without init");
	a_reg_cause: assert property (o_stat.reg_start |-> $past(i_init_done))
		else $error("registration uncaused");
	a_remove_stop: assert property (o_stat.remove_evt |-> !o_stat.card_present && !o_stat.card_access_en)
		else $error("access after removal");
	a_cfg_load: assert property (i_cfg_write |=> o_cfg == $past(i_cfg))
		else $error("config not loaded");
	a_off_quiet: assert property (!o_cfg.hot_plug_detect_enable_cmd [*2] |-> !o_stat.insert_evt)
		else $error("insert while disabled");
	a_level_ok: assert property (o_stat.insert_evt |-> $past(i_card_detect_in, 3) == o_cfg.detect_polarity_select)
		else $error("insert at wrong level");
	a_pin_settled: assert property (o_stat.insert_evt || o_stat.remove_evt |-> $past(i_card_detect_in, 200) == $past(i_card_detect_in, 3))
		else $error("event on unsettled pin");
endmodule : schp_top_chk
bind schp_top schp_top_chk schp_top_chk_i (.i_clock, .i_reset, .i_card_detect_in, .i_cfg,
	.i_cfg_write, .i_init_done, .o_cfg, .o_stat);

// [tb_schp_top.sv]
`timescale 1ns/1ps
module tb_schp_top;
	import schp_pkg::*;
	logic       i_clock = 0, i_reset = 1, ins = 0, glt = 0, wr = 0, done = 0, h, pin;
	schp_cfg_t  cfg = '0, o_cfg;
	schp_stat_t o_stat;
	int         n_errors = 0, comparisons = 0;
	// 200 MHz clock
	always #2.5 i_clock = ~i_clock;
	schp_card_model schp_card_model_i (.i_inserted(ins), .i_glitch(glt), .o_detect(pin));
	schp_top schp_top_i (.i_clock, .i_reset, .i_card_detect_in(pin), .i_cfg(cfg),
		.i_cfg_write(wr), .i_init_done(done), .o_cfg, .o_stat);
	task check(input string n, input logic [7:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : check
	// Bounded wait on one status bit; a hang cannot stall here
	task wt(input int b, n);
		h = 0;
		repeat (n) if (!h) begin
			@(negedge i_clock);
			h = o_stat[b];
		end
	endtask : wt
	task cfg_wr(input logic [1:0] v);
		cfg = schp_cfg_t'(v);
		wr = 1;
		@(negedge i_clock);
		wr = 0;
		check("cfg", o_cfg, v);
	endtask : cfg_wr
	task t_ins;
		ins = 1;
		wt(1, 2500);
		check("insert", {h, o_stat.init_start}, 2'h3);
		done = 1;
		wt(2, 1);
		done = 0;
		check("register", h, 1'h1);
	endtask : t_ins
	task t_rem;
		glt = 1;
		repeat (100) @(negedge i_clock);
		glt = 0;
		wt(0, 2500);
		check("glitch", h, 1'h0);
		ins = 0;
		wt(0, 2500);
		check("remove", {h, o_stat[5:4]}, 3'h4);
	endtask : t_rem
	task t_pol;
		cfg_wr(2'h2);
		wt(1, 9);
		check("low level", h, 1'h1);
	endtask : t_pol
	task t_off;
		cfg_wr(2'h1);
		ins = 1;
		wt(1, 2500);
		check("disabled", h, 1'h0);
	endtask : t_off
	// Mid-run reset, then detection off: one power-up read only
	task t_boot;
		ins = 0;
		i_reset = 1;
		repeat (2) @(negedge i_clock);
		i_reset = 0;
		@(negedge i_clock);
		check("reset again", {o_cfg, o_stat}, 8'hC0);
		cfg_wr(2'h1);
		wt(3, 4);
		check("boot read", {h, o_stat.insert_evt}, 2'h2);
		wt(3, 20);
		check("one read", h, 1'h0);
	endtask : t_boot
	task conclude;
		if (n_errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	// Main sequence
	initial begin
		repeat (12) @(negedge i_clock);
		i_reset = 0;
		@(negedge i_clock);
		check("reset", {o_cfg, o_stat}, 8'hC0);
		t_ins;
		t_rem;
		t_pol;
		t_off;
		t_boot;
		conclude;
	end
	// Watchdog, about four times the expected run
	initial begin
		#200us;
		n_errors++;
		conclude;
	end
endmodule : tb_schp_top
